// ==== core/logic_scan_cfg_regs.vh ====
/*
  Register offsets, field positions, reset values and timing counts for the
  logic cell, scan timing and pin assignment register group.
  Assumes a 10 MHz core clock and an 8-bit register port driven by the serial front end.
*/
// Behaviour
// (R1) Bit 6 of the logic function register inverts the logic cell output when set.
// (R2) Bits 3, 4 and 5 of the logic function register invert inputs A, B and C before the cell.
// (R3) The 3-bit function field selects off, AND, OR, XOR, flip-flop, or pass A, B or C.
// (R4) Writing 1 to bit 1 of the latch control register sets the cell flip-flop; a write with bit 0 also 1 clears it instead.
// (R5) Writing 1 to bit 0 of the latch control register clears the cell flip-flop.
// (R6) The cell output is debounced before event handling unless the bypass bit is set.
// (R7) With the event enable bit set, cell output activity queues events; cleared, none.
// (R8) The level bit picks whether a low or a high cell output counts as active.
// (R9) Bit 3 of the scan timing register selects a row precharge of 100 us or 200 us.
// (R10) The 2-bit poll field selects 10, 20, 30 or 40 ms between scan cycles.
// (R11) Each of row assignment bits 0 to 5 makes its pin keypad row n or GPIO n+1.
// (R12) Each of column assignment bits 0 to 4 makes its pin keypad column n or GPIO n+7.
// (R13) Pins in GPIO mode may take alternate functions chosen by the extended bits.
// (R14) With its extended bit set, row 0 drives the logic cell output instead of GPIO 1.
// (R15) With its extended bit set, row 3 feeds logic input C instead of GPIO 4.
// (R16) Reserved bits read as zero and writes to them are ignored.
// (R17) The host finishes pin and function setup before enabling logic events.
`ifndef LOGIC_SCAN_CFG_REGS_VH
`define LOGIC_SCAN_CFG_REGS_VH

`define ADDR_LOGIC_FUNCTION_CFG 8'h36
`define ADDR_LOGIC_LATCH_CTRL 8'h37
`define ADDR_LOGIC_EVENT_CFG 8'h38
`define ADDR_SCAN_TIMING_CFG 8'h39
`define ADDR_ROW_PIN_ASSIGN 8'h3A
`define ADDR_COLUMN_PIN_ASSIGN 8'h3B

`define MASK_LOGIC_FUNCTION_CFG 8'h7F
`define MASK_LOGIC_LATCH_CTRL 8'h03
`define MASK_LOGIC_EVENT_CFG 8'h07
`define MASK_SCAN_TIMING_CFG 8'h0B
`define MASK_ROW_PIN_ASSIGN 8'h3F
`define MASK_COLUMN_PIN_ASSIGN 8'h1F

`define RESET_CFG 8'h00

`define BIT_OUTPUT_INVERT 6
`define BIT_INPUT_C_INVERT 5
`define BIT_INPUT_B_INVERT 4
`define BIT_INPUT_A_INVERT 3
`define BIT_LATCH_SET 1
`define BIT_LATCH_CLEAR 0
`define BIT_DEBOUNCE_BYPASS 2
`define BIT_EVENT_ENABLE 1
`define BIT_ACTIVE_LEVEL 0
`define BIT_PRECHARGE_LONG 3

`define FUNC_OFF 3'h0
`define FUNC_AND 3'h1
`define FUNC_OR 3'h2
`define FUNC_XOR 3'h3
`define FUNC_FLOP 3'h4
`define FUNC_PASS_A 3'h5
`define FUNC_PASS_B 3'h6
`define FUNC_PASS_C 3'h7

`define CLK_HZ 10000000
`define PRECHARGE_SHORT_US 100
`define PRECHARGE_LONG_US 200
`define POLL_STEP_MS 10
`define PRECHARGE_SHORT_CYC ((`PRECHARGE_SHORT_US * (`CLK_HZ / 1000000)))
`define PRECHARGE_LONG_CYC ((`PRECHARGE_LONG_US * (`CLK_HZ / 1000000)))
`define POLL_STEP_CYC ((`POLL_STEP_MS * (`CLK_HZ / 1000)))
`define DEBOUNCE_CYC 4

`endif

// ==== core/logic_scan_pin_cfg.v ====
/*
  Logic cell, event detection, scan timing and pin assignment register group.
  Assumes the serial front end gives one-cycle write and read strobes with an 8-bit address,
  and that pin and logic inputs are synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "logic_scan_cfg_regs.vh"
module logic_scan_pin_cfg #(
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYC,
  parameter PRECHARGE_SHORT_CYCLES = `PRECHARGE_SHORT_CYC,
  parameter PRECHARGE_LONG_CYCLES = `PRECHARGE_LONG_CYC,
  parameter POLL_STEP_CYCLES = `POLL_STEP_CYC
) (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_b,
  // Register port from the serial front end.
  input wire [7:0] reg_addr,
  input wire reg_write,
  input wire [7:0] reg_wdata,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // Logic cell inputs from the pins.
  input wire logic_input_a,
  input wire logic_input_b,
  input wire gpio_c_in,
  input wire row3_pin_in,
  // Extended alternate-function bits from the extended pin register.
  input wire row0_alt_function,
  input wire row3_alt_function,
  input wire row4_alt_function,
  input wire col0_alt_function,
  input wire col1_alt_function,
  // Alternate sources from neighbouring blocks.
  input wire first_pulse_output,
  input wire second_pulse_output,
  input wire reset_generator_out,
  // Logic cell results.
  output reg logic_output,
  output reg logic_event,
  output reg logic_active,
  // Scan timing.
  output reg precharge_done,
  output reg scan_start,
  // Pin assignment.
  output reg [5:0] row_is_key,
  output reg [4:0] col_is_key,
  output reg row0_out,
  output reg row0_oe,
  output reg row4_out,
  output reg row4_oe,
  output reg col0_out,
  output reg col0_oe,
  output reg col1_out,
  output reg col1_oe
);
  reg [7:0] logic_function_cfg_reg;
  reg [7:0] logic_latch_ctrl_reg;
  reg [7:0] logic_event_cfg_reg;
  reg [7:0] scan_timing_cfg_reg;
  reg [7:0] row_pin_assign_reg;
  reg [7:0] column_pin_assign_reg;
  reg logic_flip_flop_reg;
  reg cell_reg;
  reg prev_clean_reg;
  reg [23:0] poll_count_reg;
  reg [15:0] pre_count_reg;
  reg precharging_reg;
  wire clean_out;
  wire in_a;
  wire in_b;
  wire in_c;
  wire raw_c;
  reg cell_next;
  reg [23:0] poll_limit;
  reg [15:0] pre_limit;
  reg [31:0] poll_product;

  function [7:0] reg_mask;
    input [7:0] addr;
    begin
      case (addr)
        `ADDR_LOGIC_FUNCTION_CFG: reg_mask = `MASK_LOGIC_FUNCTION_CFG;
        `ADDR_LOGIC_LATCH_CTRL: reg_mask = `MASK_LOGIC_LATCH_CTRL;
        `ADDR_LOGIC_EVENT_CFG: reg_mask = `MASK_LOGIC_EVENT_CFG;
        `ADDR_SCAN_TIMING_CFG: reg_mask = `MASK_SCAN_TIMING_CFG;
        `ADDR_ROW_PIN_ASSIGN: reg_mask = `MASK_ROW_PIN_ASSIGN;
        `ADDR_COLUMN_PIN_ASSIGN: reg_mask = `MASK_COLUMN_PIN_ASSIGN;
        default: reg_mask = 8'h00;
      endcase
    end
  endfunction

  // Register writes; reserved bits are masked off.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      logic_function_cfg_reg <= `RESET_CFG;
      logic_latch_ctrl_reg <= `RESET_CFG;
      logic_event_cfg_reg <= `RESET_CFG;
      scan_timing_cfg_reg <= `RESET_CFG;
      row_pin_assign_reg <= `RESET_CFG;
      column_pin_assign_reg <= `RESET_CFG;
    end else if (reg_write) begin
      case (reg_addr)
        `ADDR_LOGIC_FUNCTION_CFG: logic_function_cfg_reg <= reg_wdata & reg_mask(reg_addr); // R16
        `ADDR_LOGIC_LATCH_CTRL: logic_latch_ctrl_reg <= reg_wdata & reg_mask(reg_addr); // R16
        `ADDR_LOGIC_EVENT_CFG: logic_event_cfg_reg <= reg_wdata & reg_mask(reg_addr); // R16
        `ADDR_SCAN_TIMING_CFG: scan_timing_cfg_reg <= reg_wdata & reg_mask(reg_addr); // R16
        `ADDR_ROW_PIN_ASSIGN: row_pin_assign_reg <= reg_wdata & reg_mask(reg_addr); // R16
        `ADDR_COLUMN_PIN_ASSIGN: column_pin_assign_reg <= reg_wdata & reg_mask(reg_addr); // R16
        default: ;
      endcase
    end
  end

  // Read data is registered and appears the cycle after the strobe.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `ADDR_LOGIC_FUNCTION_CFG: reg_rdata <= logic_function_cfg_reg;
        `ADDR_LOGIC_LATCH_CTRL: reg_rdata <= logic_latch_ctrl_reg;
        `ADDR_LOGIC_EVENT_CFG: reg_rdata <= logic_event_cfg_reg;
        `ADDR_SCAN_TIMING_CFG: reg_rdata <= scan_timing_cfg_reg;
        `ADDR_ROW_PIN_ASSIGN: reg_rdata <= row_pin_assign_reg;
        `ADDR_COLUMN_PIN_ASSIGN: reg_rdata <= column_pin_assign_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Input C comes from row 3 when its alternate function is chosen.
  assign raw_c = (row3_alt_function && !row_pin_assign_reg[3]) ? row3_pin_in : gpio_c_in; // R15
  assign in_a = logic_input_a ^ logic_function_cfg_reg[`BIT_INPUT_A_INVERT]; // R2
  assign in_b = logic_input_b ^ logic_function_cfg_reg[`BIT_INPUT_B_INVERT]; // R2
  assign in_c = raw_c ^ logic_function_cfg_reg[`BIT_INPUT_C_INVERT]; // R2

  // Cell flip-flop: A clocks in data B on a rising edge; set and clear writes override.
  reg prev_a_reg;
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      logic_flip_flop_reg <= 1'b0;
      // Starts high so a pin already high after reset gives no false clock edge.
      prev_a_reg <= 1'b1;
    end else begin
      prev_a_reg <= in_a;
      if (reg_write && reg_addr == `ADDR_LOGIC_LATCH_CTRL && reg_wdata[`BIT_LATCH_CLEAR]) begin
        logic_flip_flop_reg <= 1'b0; // R5
      end else if (reg_write && reg_addr == `ADDR_LOGIC_LATCH_CTRL
                   && reg_wdata[`BIT_LATCH_SET]) begin
        logic_flip_flop_reg <= 1'b1; // R4
      end else if (in_a && !prev_a_reg) begin
        logic_flip_flop_reg <= in_b;
      end
    end
  end

  // Function select.
  always @* begin
    case (logic_function_cfg_reg[2:0]) // R3
      `FUNC_OFF: cell_next = 1'b0;
      `FUNC_AND: cell_next = in_a & in_b & in_c;
      `FUNC_OR: cell_next = in_a | in_b | in_c;
      `FUNC_XOR: cell_next = in_a ^ in_b ^ in_c;
      `FUNC_FLOP: cell_next = logic_flip_flop_reg;
      `FUNC_PASS_A: cell_next = in_a;
      `FUNC_PASS_B: cell_next = in_b;
      `FUNC_PASS_C: cell_next = in_c;
      default: cell_next = 1'b0;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      cell_reg <= 1'b0;
      logic_output <= 1'b0;
    end else begin
      cell_reg <= cell_next ^ logic_function_cfg_reg[`BIT_OUTPUT_INVERT]; // R1
      logic_output <= cell_next ^ logic_function_cfg_reg[`BIT_OUTPUT_INVERT]; // R1
    end
  end

  output_debouncer #(
    .STABLE_CYCLES(DEBOUNCE_CYCLES)
  ) debounce_inst (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .bypass(logic_event_cfg_reg[`BIT_DEBOUNCE_BYPASS]),
    .raw_in(cell_reg),
    .clean_out(clean_out)
  );

  // Event on each entry into the active level, and level for the interrupt block.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      prev_clean_reg <= 1'b0;
      logic_event <= 1'b0;
      logic_active <= 1'b0;
    end else begin
      prev_clean_reg <= clean_out;
      logic_active <= logic_event_cfg_reg[`BIT_EVENT_ENABLE]
                      && (clean_out == logic_event_cfg_reg[`BIT_ACTIVE_LEVEL]); // R7 R8
      logic_event <= logic_event_cfg_reg[`BIT_EVENT_ENABLE] && (clean_out != prev_clean_reg)
                     && (clean_out == logic_event_cfg_reg[`BIT_ACTIVE_LEVEL]); // R7 R8
    end
  end

  // Scan timing: poll interval, then row precharge, then scan start.
  always @* begin
    poll_product = POLL_STEP_CYCLES * ({30'h0, scan_timing_cfg_reg[1:0]} + 32'h00000001); // R10
    poll_limit = poll_product[23:0]; // R10
    pre_limit = scan_timing_cfg_reg[`BIT_PRECHARGE_LONG] ? PRECHARGE_LONG_CYCLES[15:0]
                : PRECHARGE_SHORT_CYCLES[15:0]; // R9
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      poll_count_reg <= 24'h000000;
      pre_count_reg <= 16'h0000;
      precharging_reg <= 1'b0;
      precharge_done <= 1'b0;
      scan_start <= 1'b0;
    end else begin
      precharge_done <= 1'b0;
      scan_start <= 1'b0;
      if (precharging_reg) begin
        if (pre_count_reg + 16'h0001 >= pre_limit) begin
          precharging_reg <= 1'b0;
          pre_count_reg <= 16'h0000;
          precharge_done <= 1'b1; // R9
          scan_start <= 1'b1;
        end else begin
          pre_count_reg <= pre_count_reg + 16'h0001;
        end
      end else if (poll_count_reg + 24'h000001 >= poll_limit) begin
        poll_count_reg <= 24'h000000;
        precharging_reg <= 1'b1; // R10
      end else begin
        poll_count_reg <= poll_count_reg + 24'h000001;
      end
    end
  end

  // Pin assignment and alternate functions.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      row_is_key <= 6'h00;
      col_is_key <= 5'h00;
      row0_out <= 1'b0;
      row0_oe <= 1'b0;
      row4_out <= 1'b0;
      row4_oe <= 1'b0;
      col0_out <= 1'b0;
      col0_oe <= 1'b0;
      col1_out <= 1'b0;
      col1_oe <= 1'b0;
    end else begin
      row_is_key <= row_pin_assign_reg[5:0]; // R11
      col_is_key <= column_pin_assign_reg[4:0]; // R12
      row0_out <= cell_next ^ logic_function_cfg_reg[`BIT_OUTPUT_INVERT]; // R14
      row0_oe <= row0_alt_function && !row_pin_assign_reg[0]; // R14
      row4_out <= reset_generator_out; // R13
      row4_oe <= row4_alt_function && !row_pin_assign_reg[4]; // R13
      col0_out <= first_pulse_output; // R13
      col0_oe <= col0_alt_function && !column_pin_assign_reg[0]; // R13
      col1_out <= second_pulse_output; // R13
      col1_oe <= col1_alt_function && !column_pin_assign_reg[1]; // R13
    end
  end
endmodule
`default_nettype wire

// ==== core/output_debouncer.v ====
/*
  Debounces the logic cell output, or passes it straight through when bypassed.
  Assumes the input is synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module output_debouncer #(
  parameter STABLE_CYCLES = 4
) (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_b,
  // Signal path.
  input wire bypass,
  input wire raw_in,
  output reg clean_out
);
  reg [7:0] stable_count_reg;
  reg last_reg;

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      stable_count_reg <= 8'h00;
      last_reg <= 1'b0;
      clean_out <= 1'b0;
    end else begin
      last_reg <= raw_in;
      if (bypass) begin
        clean_out <= raw_in; // R6
        stable_count_reg <= 8'h00;
      end else if (raw_in != last_reg) begin
        stable_count_reg <= 8'h00;
      end else if (stable_count_reg < STABLE_CYCLES[7:0]) begin
        stable_count_reg <= stable_count_reg + 8'h01;
      end else begin
        clean_out <= last_reg; // R6
      end
    end
  end
endmodule
`default_nettype wire

// ==== verif/host_port_model.sv ====
/* Host side of the register port: one-cycle write and read strobes.
   Assumes strobes are taken on the rising edge of ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  // Clock.
  input wire logic ref_clk,
  // Register port.
  output logic [7:0] reg_addr,
  output logic reg_write,
  output logic [7:0] reg_wdata,
  output logic reg_read,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    reg_read = 1'b0;
  end
  // Released data shows the inverse so a stale byte never looks valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge ref_clk);
    reg_read = 1'b0;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ==== verif/logic_scan_pin_cfg_test.sv ====
/* Self-checking bench for the logic, scan and pin register group.
   Inputs change on the falling edge; registers go through the host model. */
`timescale 1ns/1ps
`default_nettype none
module logic_scan_pin_cfg_test;
  localparam int PS = 20;
  localparam int PSH = 5;
  localparam int PL = 10;
  logic ref_clk;
  logic rst_b;
  logic [11:0] pins;
  int bad_count;
  int checks;
  wire [7:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire reg_write;
  wire reg_read;
  wire logic_output;
  wire logic_event;
  wire logic_active;
  wire precharge_done;
  wire scan_start;
  wire [5:0] row_is_key;
  wire [4:0] col_is_key;
  wire [7:0] drv;
  logic [7:0] mk [7] = '{8'h7F, 8'h03, 8'h07, 8'h0B, 8'h3F, 8'h1F, 8'h00};
  host_port_model H (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata));
  logic_scan_pin_cfg #(.DEBOUNCE_CYCLES(4), .PRECHARGE_SHORT_CYCLES(PSH),
    .PRECHARGE_LONG_CYCLES(PL), .POLL_STEP_CYCLES(PS)) DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .logic_input_a(pins[0]), .logic_input_b(pins[1]), .gpio_c_in(pins[2]),
    .row3_pin_in(pins[3]), .row0_alt_function(pins[4]), .row3_alt_function(pins[5]),
    .row4_alt_function(pins[6]), .col0_alt_function(pins[7]), .col1_alt_function(pins[8]),
    .first_pulse_output(pins[9]), .second_pulse_output(pins[10]),
    .reset_generator_out(pins[11]), .logic_output(logic_output), .logic_event(logic_event),
    .logic_active(logic_active), .precharge_done(precharge_done), .scan_start(scan_start),
    .row_is_key(row_is_key), .col_is_key(col_is_key), .row0_out(drv[7]), .row0_oe(drv[6]),
    .row4_out(drv[5]), .row4_oe(drv[4]), .col0_out(drv[3]), .col0_oe(drv[2]),
    .col1_out(drv[1]), .col1_oe(drv[0]));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Counts falling edges until an event or a scan pulse, within a bound.
  task automatic wfor(input bit scan, output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while ((scan ? scan_start : logic_event) !== 1'b1 && n < 200);
    if (n == 200) begin
      chk(n, 0);
      end_sim;
    end
  endtask
  task automatic t_regs;
    logic [7:0] d;
    for (int i = 0; i < 7; i++) begin
      H.rd(8'h36 + i[7:0], d);
      chk(d, 8'h00);
      H.wr(8'h36 + i[7:0], 8'hFF);
      H.rd(8'h36 + i[7:0], d);
      chk(d, mk[i]);
      H.wr(8'h36 + i[7:0], 8'h00);
    end
  endtask
  task automatic t_pins;
    pins = 12'hFF1;
    H.wr(8'h36, 8'h05);
    H.wr(8'h3A, 8'h00);
    H.wr(8'h3B, 8'h00);
    wt(3);
    chk(drv, 8'hFF);
    pins = 12'h1F0;
    wt(2);
    chk(drv, 8'h55);
    H.wr(8'h3A, 8'h15);
    H.wr(8'h3B, 8'h0A);
    wt(3);
    chk({row_is_key, col_is_key, drv[6], drv[4], drv[2], drv[0]}, {6'h15, 5'h0A, 4'h2});
  endtask
  task automatic t_logic;
    logic a;
    logic b;
    logic c;
    logic y;
    for (int n = 0; n < 2; n++) begin
      for (int f = 0; f < 8; f++) begin
        if (f == 4) continue;
        H.wr(8'h36, {1'b0, {4{n[0]}}, f[2:0]});
        for (int v = 0; v < 8; v++) begin
          pins = {9'h000, v[2:0]};
          wt(2);
          a = v[0] ^ n[0];
          b = v[1] ^ n[0];
          c = v[2] ^ n[0];
          case (f)
            0: y = 1'b0;
            1: y = a & b & c;
            2: y = a | b | c;
            3: y = a ^ b ^ c;
            5: y = a;
            6: y = b;
            default: y = c;
          endcase
          chk(logic_output, y ^ n[0]);
        end
      end
    end
  endtask
  task automatic t_flop;
    pins = 12'h000;
    H.wr(8'h36, 8'h04);
    H.wr(8'h37, 8'h01);
    wt(2);
    chk(logic_output, 1'b0);
    H.wr(8'h37, 8'h02);
    wt(2);
    chk(logic_output, 1'b1);
    H.wr(8'h37, 8'h00);
    wt(2);
    chk(logic_output, 1'b1);
    H.wr(8'h37, 8'h01);
    wt(2);
    chk(logic_output, 1'b0);
    pins = 12'h002;
    wt(2);
    pins = 12'h003;
    wt(2);
    chk(logic_output, 1'b1);
    H.wr(8'h37, 8'h03);
    wt(2);
    chk(logic_output, 1'b0);
  endtask
  task automatic t_row3;
    pins = 12'h028;
    H.wr(8'h36, 8'h07);
    wt(2);
    chk(logic_output, 1'b1);
    pins = 12'h024;
    wt(2);
    chk(logic_output, 1'b0);
  endtask
  task automatic t_event;
    int n;
    pins = 12'h000;
    H.wr(8'h36, 8'h05);
    H.wr(8'h38, 8'h03);
    wt(10);
    pins = 12'h001;
    wt(2);
    pins = 12'h000;
    for (int i = 0; i < 12; i++) begin
      @(negedge ref_clk);
      chk(logic_event, 1'b0);
    end
    pins = 12'h001;
    wfor(0, n);
    chk(n >= 5 && n <= 9, 1'b1);
    chk(logic_active, 1'b1);
    H.wr(8'h38, 8'h07);
    pins = 12'h000;
    wt(4);
    pins = 12'h001;
    wfor(0, n);
    chk(n <= 3, 1'b1);
    H.wr(8'h38, 8'h02);
    pins = 12'h000;
    wfor(0, n);
    chk(n >= 5 && n <= 9, 1'b1);
    H.wr(8'h38, 8'h01);
    pins = 12'h001;
    for (int i = 0; i < 12; i++) begin
      @(negedge ref_clk);
      chk({logic_event, logic_active}, 2'b00);
    end
  endtask
  task automatic t_scan;
    int n;
    int e;
    for (int k = 0; k < 8; k++) begin
      H.wr(8'h39, {4'h0, k[2], 1'b0, k[1:0]});
      wfor(1, n);
      wfor(1, n);
      wfor(1, n);
      chk({precharge_done, scan_start}, 2'b11);
      e = (k % 4 + 1) * PS + (k[2] ? PL : PSH);
      chk(n >= e && n <= e + 2, 1'b1);
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    rst_b = 1'b0;
    pins = 12'h000;
    bad_count = 0;
    checks = 0;
    wt(2);
    rst_b = 1'b1;
    t_regs;
    t_pins;
    t_logic;
    t_flop;
    t_row3;
    t_event;
    t_scan;
    end_sim;
  end
endmodule
`default_nettype wire

// ==== verif/scan_cfg_props.sv ====
/* Checker for the logic, scan and pin register group.
   Bound to logic_scan_pin_cfg and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module scan_cfg_props (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Cell, scan and pins.
  input wire logic logic_input_a,
  input wire logic logic_output,
  input wire logic logic_event,
  input wire logic logic_active,
  input wire logic scan_start,
  input wire logic precharge_done,
  input wire logic row0_alt_function,
  input wire logic row0_oe,
  input wire logic [5:0] row_is_key,
  input wire logic [4:0] col_is_key
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  logic [7:0] fq;
  logic [7:0] mq;
  logic en_q;
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h36: msk = 8'h7F;
      8'h37: msk = 8'h03;
      8'h38: msk = 8'h07;
      8'h39: msk = 8'h0B;
      8'h3A: msk = 8'h3F;
      8'h3B: msk = 8'h1F;
      default: msk = 8'h00;
    endcase
  endfunction
  // Shadows of the written fields.
  always_ff @(posedge ref_clk) begin
    mq <= msk(reg_addr);
    if (!rst_b) begin
      fq <= 8'h00;
      en_q <= 1'b0;
    end else if (reg_write && reg_addr == 8'h36) begin
      fq <= reg_wdata & 8'h7F;
    end else if (reg_write && reg_addr == 8'h38) begin
      en_q <= reg_wdata[1];
    end
  end
  property p_rd_mask; reg_read |=> (reg_rdata & ~mq) == 8'h00; endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("reserved bit read high");
  property p_row;
    reg_write && reg_addr == 8'h3A |-> ##2 row_is_key == $past(reg_wdata[5:0], 2);
  endproperty
  a_row: assert property (p_row) else $error("row assignment wrong");
  property p_col;
    reg_write && reg_addr == 8'h3B |-> ##2 col_is_key == $past(reg_wdata[4:0], 2);
  endproperty
  a_col: assert property (p_col) else $error("column assignment wrong");
  property p_pass_a;
    fq[2:0] == 3'h5 && $stable(fq) |-> logic_output == ($past(logic_input_a) ^ fq[3] ^ fq[6]);
  endproperty
  a_pass_a: assert property (p_pass_a) else $error("pass A output wrong");
  property p_ev_pulse; logic_event |=> !logic_event; endproperty
  a_ev_pulse: assert property (p_ev_pulse) else $error("event longer than one cycle");
  property p_ev_lvl; logic_event |-> logic_active; endproperty
  a_ev_lvl: assert property (p_ev_lvl) else $error("event outside active level");
  property p_ev_en; !en_q [*3] |-> !logic_event && !logic_active; endproperty
  a_ev_en: assert property (p_ev_en) else $error("event while disabled");
  property p_scan_pair;
    scan_start || precharge_done |-> scan_start && precharge_done;
  endproperty
  a_scan_pair: assert property (p_scan_pair) else $error("scan before precharge end");
  property p_scan_gap; scan_start |=> !scan_start [*8]; endproperty
  a_scan_gap: assert property (p_scan_gap) else $error("scan cycles too close");
  property p_row0_oe; !row0_alt_function [*2] |-> !row0_oe; endproperty
  a_row0_oe: assert property (p_row0_oe) else $error("row 0 driven as GPIO");
endmodule
bind logic_scan_pin_cfg scan_cfg_props P (.ref_clk(ref_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .logic_input_a(logic_input_a), .logic_output(logic_output),
  .logic_event(logic_event), .logic_active(logic_active), .scan_start(scan_start),
  .precharge_done(precharge_done), .row0_alt_function(row0_alt_function),
  .row0_oe(row0_oe), .row_is_key(row_is_key), .col_is_key(col_is_key));
`default_nettype wire
